// >>> design/meo_defs.svh
// constants for the motor enable and overtravel control block
// Functional notes
// - request polarity 0/1: closed/open enables power
// - request polarity 2/3: power forced on/off
// - forward cfg 0/1: open/closed blocks forward
// - forward cfg 2 blocks, 3 ignores input
// - reverse cfg 0/1: open/closed blocks reverse
// - reverse cfg 2 blocks, 3 ignores input
// - opposite direction motion still accepted, except with stop method 0
// - overtravel aborts positioning to target
// - stop method 0: use servo-off method
// - stop method 1: immediate halt, servo-lock
// - stop method 2: decelerate, then servo-lock
// - decel rate 1..99999999, default 1000, immediate
// - overtravel servo-off latched until request re-asserted, serial enable command or restart
`ifndef MEO_DEFS_SVH
`define MEO_DEFS_SVH
`define MEO_ADDR_CTRL    8'h00
`define MEO_ADDR_DECEL   8'h04
`define MEO_ADDR_STATUS  8'h08
`define MEO_ADDR_IRQ_ST  8'h0C
`define MEO_ADDR_IRQ_MSK 8'h10
`define MEO_ADDR_CMD     8'h14
`define MEO_CTRL_RESET   32'h0000_0000
`define MEO_DECEL_RESET  27'h00003E8
`define MEO_DECEL_MAX    27'h5F5E0FF
`define MEO_DECEL_MIN    27'h0000001
`define MEO_CTRL_PWR_LSB 0
`define MEO_CTRL_FWD_LSB 2
`define MEO_CTRL_REV_LSB 4
`define MEO_CTRL_STP_LSB 6
`define MEO_CTRL_SOF_LSB 8
`define MEO_IRQ_FWD      0
`define MEO_IRQ_REV      1
`define MEO_IRQ_LATCH    2
`define MEO_IRQ_ABORT    3
`define MEO_CMD_RESTART_BIT 1
`endif

// >>> design/meo_pkg.sv
// types for the motor enable and overtravel control block
package meo_pkg;
  typedef enum logic [1:0] {
    MEO_STOP_SAME  = 2'b00,
    MEO_STOP_IMMED = 2'b01,
    MEO_STOP_DECEL = 2'b10,
    MEO_STOP_RSVD  = 2'b11
  } meo_stop_t;
  typedef enum logic [1:0] {
    MEO_ST_RUN   = 2'b00,
    MEO_ST_STOP  = 2'b01,
    MEO_ST_LOCK  = 2'b10,
    MEO_ST_OFF   = 2'b11
  } meo_state_t;
  typedef struct packed {
    logic        fwd_ref;
    logic        rev_ref;
    logic        target_req;
    logic        at_standstill;
  } meo_motion_in_t;
  typedef struct packed {
    logic        power_on;
    logic        fwd_allow;
    logic        rev_allow;
    logic        quick_stop;
    logic        decel_stop;
    logic        servo_lock;
    logic        coast_stop;
    logic        target_abort;
    logic [26:0] decel_rate;
  } meo_drive_out_t;
endpackage

// >>> design/meo_ctrl.sv
// motor enable, limit switch and overtravel stop control with axi4-lite registers
`timescale 1ns/1ps
`include "meo_defs.svh"
module meo_ctrl (
  input  wire logic                    sys_clk,
  input  wire logic                    rstn,
  input  wire logic                    power_request_input,
  input  wire logic                    forward_limit_input,
  input  wire logic                    reverse_limit_input,
  input  wire meo_pkg::meo_motion_in_t motion_in,
  output meo_pkg::meo_drive_out_t      drive_out,
  output logic                         irq,
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready
);
  import meo_pkg::*;

  // input synchronisers; stage 1 feeds only stage 2
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= {reverse_limit_input, forward_limit_input, power_request_input};
      sync2_q <= sync1_q;
    end
  end
  wire req_closed = sync2_q[0];
  wire fwd_closed = sync2_q[1];
  wire rev_closed = sync2_q[2];

  // software-staged settings, applied only at restart
  logic [31:0] ctrl_q;
  logic [26:0] decel_q;
  logic [1:0]  pwr_sel_q;
  logic [1:0]  fwd_cfg_q;
  logic [1:0]  rev_cfg_q;
  meo_stop_t   stop_q;
  logic [1:0]  soff_q;
  logic        cfg_done_q;
  logic        restart_cmd;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_done_q <= 1'b0;
      pwr_sel_q  <= 2'h0;
      fwd_cfg_q  <= 2'h0;
      rev_cfg_q  <= 2'h0;
      stop_q     <= MEO_STOP_SAME;
      soff_q     <= 2'h0;
    end else if (restart_cmd) begin
      // soft restart keeps ctrl_q, so staged settings survive into the reload
      cfg_done_q <= 1'b0;
    end else if (!cfg_done_q) begin
      cfg_done_q <= 1'b1;
      pwr_sel_q  <= ctrl_q[`MEO_CTRL_PWR_LSB +: 2];
      fwd_cfg_q  <= ctrl_q[`MEO_CTRL_FWD_LSB +: 2];
      rev_cfg_q  <= ctrl_q[`MEO_CTRL_REV_LSB +: 2];
      stop_q     <= meo_stop_t'(ctrl_q[`MEO_CTRL_STP_LSB +: 2]);
      soff_q     <= ctrl_q[`MEO_CTRL_SOF_LSB +: 2];
    end
  end

  // power request decode
  wire req_active = (pwr_sel_q == 2'h0) ? req_closed :
                    (pwr_sel_q == 2'h1) ? !req_closed :
                    (pwr_sel_q == 2'h2);
  wire forced_on  = (pwr_sel_q == 2'h2);

  // limit decode: 0 open blocks, 1 closed blocks, 2 always, 3 never
  wire fwd_block = (fwd_cfg_q == 2'h0) ? !fwd_closed :
                   (fwd_cfg_q == 2'h1) ? fwd_closed :
                   (fwd_cfg_q == 2'h2);
  wire rev_block = (rev_cfg_q == 2'h0) ? !rev_closed :
                   (rev_cfg_q == 2'h1) ? rev_closed :
                   (rev_cfg_q == 2'h2);

  // overtravel only acts when motion heads into the blocked side
  wire ot_fwd  = fwd_block && motion_in.fwd_ref;
  wire ot_rev  = rev_block && motion_in.rev_ref;
  wire ot_hit  = ot_fwd || ot_rev;

  // latch of overtravel-caused servo-off
  logic       req_prev_q;
  logic       ot_latch_q;
  logic       serial_enable_command_cmd;
  wire        req_rise = req_active && !req_prev_q;
  wire        ot_off   = cfg_done_q && ot_hit && (stop_q == MEO_STOP_SAME);
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      req_prev_q <= 1'b0;
      ot_latch_q <= 1'b0;
    end else begin
      req_prev_q <= req_active;
      // forced-on never rises again, so only a supply cycle or the serial enable command clears it
      if (ot_off)
        ot_latch_q <= 1'b1;
      else if (req_rise || serial_enable_command_cmd || !cfg_done_q)
        ot_latch_q <= 1'b0;
    end
  end

  // stop sequencing
  meo_state_t st_q;
  meo_state_t st_d;
  wire power_ok = cfg_done_q && req_active && !ot_latch_q && !ot_off;
  always_comb begin
    st_d = st_q;
    case (st_q)
      MEO_ST_OFF: begin
        if (power_ok)
          st_d = MEO_ST_RUN;
      end
      MEO_ST_RUN: begin
        if (!power_ok)
          st_d = MEO_ST_OFF;
        else if (ot_hit && stop_q == MEO_STOP_IMMED)
          st_d = MEO_ST_LOCK;
        else if (ot_hit && stop_q == MEO_STOP_DECEL)
          st_d = MEO_ST_STOP;
      end
      MEO_ST_STOP: begin
        if (!power_ok)
          st_d = MEO_ST_OFF;
        else if (motion_in.at_standstill)
          st_d = MEO_ST_LOCK;
      end
      MEO_ST_LOCK: begin
        if (!power_ok)
          st_d = MEO_ST_OFF;
        else if (!ot_hit)
          st_d = MEO_ST_RUN;
      end
      default: st_d = MEO_ST_OFF;
    endcase
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      st_q <= MEO_ST_OFF;
    else
      st_q <= st_d;
  end

  // registered drive outputs
  meo_drive_out_t drv_d;
  always_comb begin
    drv_d              = '0;
    drv_d.power_on     = (st_d != MEO_ST_OFF);
    drv_d.fwd_allow    = (st_d != MEO_ST_OFF) && !fwd_block;
    drv_d.rev_allow    = (st_d != MEO_ST_OFF) && !rev_block;
    drv_d.quick_stop   = (st_d == MEO_ST_LOCK) && (stop_q == MEO_STOP_IMMED);
    drv_d.decel_stop   = (st_d == MEO_ST_STOP);
    drv_d.servo_lock   = (st_d == MEO_ST_LOCK);
    drv_d.coast_stop   = (st_d == MEO_ST_OFF) && soff_q[0];
    drv_d.target_abort = motion_in.target_req && (fwd_block || rev_block);
    drv_d.decel_rate   = decel_q;
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      drive_out <= '0;
    else
      drive_out <= drv_d;
  end

  // interrupt status: set wins over write-one clear
  logic [3:0] irq_st_q;
  logic [3:0] irq_msk_q;
  wire  [3:0] irq_ev = {drv_d.target_abort && !drive_out.target_abort,
                        ot_off && !ot_latch_q, ot_rev, ot_fwd};
  assign irq = |(irq_st_q & irq_msk_q);

  // axi4-lite slave
  logic aw_q;
  logic w_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire   wr_go   = aw_q && w_q;
  wire   wr_ctrl = wr_go && (awaddr_q == `MEO_ADDR_CTRL);
  wire   wr_dec  = wr_go && (awaddr_q == `MEO_ADDR_DECEL);
  wire   wr_ist  = wr_go && (awaddr_q == `MEO_ADDR_IRQ_ST);
  wire   wr_msk  = wr_go && (awaddr_q == `MEO_ADDR_IRQ_MSK);
  wire   wr_cmd  = wr_go && (awaddr_q == `MEO_ADDR_CMD);
  wire   wr_hit  = wr_ctrl || wr_dec || wr_ist || wr_msk || wr_cmd;
  wire   dec_ok  = (wdata_q[26:0] >= `MEO_DECEL_MIN) && (wdata_q[26:0] <= `MEO_DECEL_MAX);
  assign serial_enable_command_cmd = wr_cmd && wstrb_q[0] && wdata_q[0];
  assign restart_cmd = wr_cmd && wstrb_q[0] && wdata_q[`MEO_CMD_RESTART_BIT];
  wire [31:0] stat_w = {22'h0, st_q, ot_latch_q, req_active, rev_block, fwd_block,
                        rev_closed, fwd_closed, req_closed, cfg_done_q};
  wire [31:0] cfg_w  = {22'h0, soff_q, stop_q, rev_cfg_q, fwd_cfg_q, pwr_sel_q};
  wire [31:0] rd_w;
  wire        rd_hit;
  assign rd_w = (s_axi_araddr == `MEO_ADDR_CTRL)    ? ctrl_q :
                (s_axi_araddr == `MEO_ADDR_DECEL)   ? {5'h0, decel_q} :
                (s_axi_araddr == `MEO_ADDR_STATUS)  ? (stat_w | {cfg_w[15:0], 16'h0}) :
                (s_axi_araddr == `MEO_ADDR_IRQ_ST)  ? {28'h0, irq_st_q} :
                (s_axi_araddr == `MEO_ADDR_IRQ_MSK) ? {28'h0, irq_msk_q} : 32'h0;
  assign rd_hit = (s_axi_araddr == `MEO_ADDR_CTRL) || (s_axi_araddr == `MEO_ADDR_DECEL) ||
                  (s_axi_araddr == `MEO_ADDR_STATUS) || (s_axi_araddr == `MEO_ADDR_IRQ_ST) ||
                  (s_axi_araddr == `MEO_ADDR_IRQ_MSK) || (s_axi_araddr == `MEO_ADDR_CMD);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 8'h0;
      wdata_q  <= 32'h0;
      wstrb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= 2'h0;
      s_axi_rdata  <= 32'h0;
    end else begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_w;
        s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q    <= `MEO_CTRL_RESET;
      decel_q   <= `MEO_DECEL_RESET;
      irq_st_q  <= 4'h0;
      irq_msk_q <= 4'h0;
    end else begin
      if (wr_ctrl && wstrb_q[0])
        ctrl_q[7:0] <= wdata_q[7:0];
      if (wr_ctrl && wstrb_q[1])
        ctrl_q[9:8] <= wdata_q[9:8];
      // out-of-range rates are dropped, takes effect at once
      if (wr_dec && (&wstrb_q) && dec_ok)
        decel_q <= wdata_q[26:0];
      if (wr_msk && wstrb_q[0])
        irq_msk_q <= wdata_q[3:0];
      irq_st_q <= irq_ev | (irq_st_q & ~((wr_ist && wstrb_q[0]) ? wdata_q[3:0] : 4'h0));
    end
  end

  // checks
  property p_forced_off;
    @(posedge sys_clk) disable iff (!rstn)
      (cfg_done_q && pwr_sel_q == 2'h3) |=> !drive_out.power_on;
  endproperty
  a_forced_off: assert property (p_forced_off) else $error("power on while forced off");

  property p_fwd_block;
    @(posedge sys_clk) disable iff (!rstn)
      (cfg_done_q && fwd_cfg_q == 2'h2) |=> !drive_out.fwd_allow;
  endproperty
  a_fwd_block: assert property (p_fwd_block) else $error("forward allowed while blocked");

  property p_rev_open;
    @(posedge sys_clk) disable iff (!rstn)
      (cfg_done_q && rev_cfg_q == 2'h0 && rev_closed && st_d != MEO_ST_OFF)
        |=> drive_out.rev_allow;
  endproperty
  a_rev_open: assert property (p_rev_open) else $error("reverse wrongly blocked");

  property p_latch_hold;
    @(posedge sys_clk) disable iff (!rstn)
      (cfg_done_q && ot_latch_q && !req_rise && !serial_enable_command_cmd) |=> ot_latch_q;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("overtravel latch lost");

  property p_latch_off;
    @(posedge sys_clk) disable iff (!rstn)
      ot_latch_q |-> ##1 !drive_out.power_on;
  endproperty
  a_latch_off: assert property (p_latch_off) else $error("power on while latched");

  property p_cfg_fixed;
    @(posedge sys_clk) disable iff (!rstn)
      $past(cfg_done_q) |-> $stable(pwr_sel_q) && $stable(stop_q);
  endproperty
  a_cfg_fixed: assert property (p_cfg_fixed) else $error("restart setting changed");

  property p_immed;
    @(posedge sys_clk) disable iff (!rstn)
      (st_q == MEO_ST_RUN && power_ok && ot_hit && stop_q == MEO_STOP_IMMED)
        |=> drive_out.servo_lock && drive_out.quick_stop;
  endproperty
  a_immed: assert property (p_immed) else $error("no immediate stop");

  property p_decel;
    @(posedge sys_clk) disable iff (!rstn)
      (st_q == MEO_ST_STOP && power_ok && motion_in.at_standstill) |=> st_q == MEO_ST_LOCK;
  endproperty
  a_decel: assert property (p_decel) else $error("no lock after decel");

  property p_decel_range;
    @(posedge sys_clk) disable iff (!rstn)
      (decel_q >= `MEO_DECEL_MIN) && (decel_q <= `MEO_DECEL_MAX);
  endproperty
  a_decel_range: assert property (p_decel_range) else $error("decel out of range");

  property p_abort;
    @(posedge sys_clk) disable iff (!rstn)
      (motion_in.target_req && fwd_block) |=> drive_out.target_abort;
  endproperty
  a_abort: assert property (p_abort) else $error("target not aborted");

  property p_same_off;
    @(posedge sys_clk) disable iff (!rstn)
      ot_off |=> !drive_out.power_on ##1 ot_latch_q;
  endproperty
  a_same_off: assert property (p_same_off) else $error("overtravel did not servo off");

  property p_opp_dir;
    @(posedge sys_clk) disable iff (!rstn)
      (st_d != MEO_ST_OFF && fwd_block && !rev_block) |=> drive_out.rev_allow;
  endproperty
  a_opp_dir: assert property (p_opp_dir) else $error("opposite direction refused");
endmodule

// >>> tb/meo_host_model.sv
// host controller and limit switch model facing the overtravel block
`timescale 1ns/1ps
module meo_host_model (
  input  wire logic                    sys_clk,
  input  wire logic                    rstn,
  input  wire logic [5:0]              cmd,
  input  wire logic                    slow,
  input  wire meo_pkg::meo_drive_out_t drive_out,
  output logic                         power_request_input,
  output logic                         forward_limit_input,
  output logic                         reverse_limit_input,
  output meo_pkg::meo_motion_in_t      motion_in
);
  import meo_pkg::*;
  logic [3:0] stop_cnt_q;
  wire  [3:0] stop_lim = slow ? 4'hC : 4'h1;
  wire        moving   = motion_in.fwd_ref | motion_in.rev_ref;
  initial begin
    {power_request_input, forward_limit_input, reverse_limit_input} = 3'h0;
    motion_in  = '0;
    stop_cnt_q = 4'h0;
  end
  // contacts are wiring, not device state, so the drive reset leaves them alone
  // request toggling comes through cmd, supply cycling is a bench restart
  always @(posedge sys_clk) begin
    {power_request_input, forward_limit_input, reverse_limit_input} <= cmd[5:3];
    motion_in.fwd_ref    <= cmd[2];
    motion_in.rev_ref    <= cmd[1];
    motion_in.target_req <= cmd[0];
  end
  // standstill arrives late when slow, so the decel stop is not ended too soon
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stop_cnt_q <= 4'h0;
    end else if (drive_out.decel_stop | drive_out.quick_stop) begin
      stop_cnt_q <= (stop_cnt_q == stop_lim) ? stop_cnt_q : stop_cnt_q + 4'h1;
    end else begin
      stop_cnt_q <= 4'h0;
    end
  end
  always @(posedge sys_clk) begin
    motion_in.at_standstill <= !moving || (stop_cnt_q == stop_lim);
  end
endmodule

// >>> tb/motor_enable_overtravel_ctrl_bench.sv
// self-checking bench for the motor enable and overtravel control block
`timescale 1ns/1ps
`include "meo_defs.svh"
module motor_enable_overtravel_ctrl_bench;
  import meo_pkg::*;
  logic           sys_clk = 0, rstn = 0, slow = 0, irq;
  logic [5:0]     cmd = 6'h00;
  logic           req_i, fwd_i, rev_i;
  meo_motion_in_t motion_in;
  meo_drive_out_t drive_out;
  logic [7:0]     awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]    wdata = 32'h0, rdata, rd_q;
  logic [3:0]     wstrb = 4'hF;
  logic           awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic           awready, wready, bvalid, arready, rvalid;
  logic [1:0]     bresp, rresp, bresp_q, rresp_q;
  int             fail_count = 0, samples_checked = 0, c, k, m;
  logic [31:0]    v, d, sof;
  logic           pw;
  always #5 sys_clk = ~sys_clk;
  meo_ctrl i_meo_ctrl (.sys_clk(sys_clk), .rstn(rstn), .power_request_input(req_i),
    .forward_limit_input(fwd_i), .reverse_limit_input(rev_i), .motion_in(motion_in),
    .drive_out(drive_out), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  meo_host_model i_meo_host_model (.sys_clk(sys_clk), .rstn(rstn), .cmd(cmd), .slow(slow),
    .drive_out(drive_out), .power_request_input(req_i), .forward_limit_input(fwd_i),
    .reverse_limit_input(rev_i), .motion_in(motion_in));
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // handshakes are sampled at the falling edge, where they equal the next rising edge
  task wr(input logic [7:0] a, input logic [31:0] dat);
    logic aw, w, ha, hw, hb;
    int   n;
    @(posedge sys_clk);
    awaddr <= a; wdata <= dat; awvalid <= 1; wvalid <= 1; bready <= 1;
    aw = 1; w = 1;
    for (n = 0; n < 60; n++) begin
      @(negedge sys_clk);
      ha = awready; hw = wready; hb = bvalid; bresp_q = bresp;
      @(posedge sys_clk);
      if (aw && ha) begin awvalid <= 0; aw = 0; end
      if (w && hw) begin wvalid <= 0; w = 0; end
      if (hb) begin bready <= 0; break; end
    end
    if (n == 60) check("write answer", 0, 1);
  endtask
  task rd(input logic [7:0] a);
    logic ar, hr;
    int   n;
    @(posedge sys_clk);
    araddr <= a; arvalid <= 1; rready <= 1; ar = 1;
    for (n = 0; n < 60; n++) begin
      @(negedge sys_clk);
      hr = arready; rd_q = rdata; rresp_q = rresp;
      @(posedge sys_clk);
      if (ar && hr) begin arvalid <= 0; ar = 0; end
      if (rvalid === 1'b1 && !ar) begin rready <= 0; break; end
    end
    if (n == 60) check("read answer", 0, 1);
  endtask
  task do_reset(input int n);
    @(posedge sys_clk);
    rstn <= 0;
    repeat (n) @(posedge sys_clk);
    rstn <= 1;
  endtask
  task set_cmd(input logic [5:0] val);
    @(posedge sys_clk);
    cmd <= val;
  endtask
  task settle;
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  function logic pwr_exp(input logic [1:0] cf, input logic req);
    return (cf == 2'd0) ? req : (cf == 2'd1) ? !req : (cf == 2'd2);
  endfunction
  function logic allow_exp(input logic [1:0] cf, input logic closed);
    return (cf == 2'd0) ? closed : (cf == 2'd1) ? !closed : (cf == 2'd3);
  endfunction
  // drive a reference into a limit that opens, then free the limit again
  task ot_trip(input int mt, input logic rv);
    logic sq, sd, done;
    int   n;
    set_cmd(rv ? 6'b110011 : 6'b101101);
    sq = 0; sd = 0; done = 0;
    for (n = 0; n < 200 && !done; n++) begin
      @(negedge sys_clk);
      sq |= drive_out.quick_stop;
      sd |= drive_out.decel_stop;
      done = (mt == 0) ? !drive_out.power_on : drive_out.servo_lock;
    end
    check("stopped", done, 1);
    check("abort", drive_out.target_abort, 1);
    if (mt == 1) check("quick stop", sq, 1);
    if (mt == 2) check("decel stop", sd, 1);
    if (mt == 0) check("coast", drive_out.coast_stop, sof[0]);
    if (mt != 0) check("other way", rv ? drive_out.fwd_allow : drive_out.rev_allow, 1);
    rd(`MEO_ADDR_IRQ_ST);
    check("events", rd_q, 32'h8 | (mt == 0 ? 32'h4 : 32'h0) | (rv ? 32'h2 : 32'h1));
    set_cmd(6'b111000);
    settle;
    check("after clear", drive_out.power_on, mt != 0);
    if (mt == 0) begin
      wr(`MEO_ADDR_IRQ_MSK, 32'h4);
      @(negedge sys_clk);
      check("irq on", irq, 1);
      wr(`MEO_ADDR_IRQ_MSK, 32'h0);
      @(negedge sys_clk);
      check("irq masked", irq, 0);
    end
    wr(`MEO_ADDR_IRQ_ST, 32'hF);
    rd(`MEO_ADDR_IRQ_ST);
    check("events cleared", rd_q, 0);
  endtask
  // soft restart stands in for a supply cycle: settings reload, latch clears
  task restart;
    wr(`MEO_ADDR_CMD, 32'h1 << `MEO_CMD_RESTART_BIT);
  endtask
  initial begin
    v = $urandom(32'h43e7);
    do_reset(12);
    rd(`MEO_ADDR_CTRL);
    check("ctrl reset", rd_q, `MEO_CTRL_RESET);
    rd(`MEO_ADDR_DECEL);
    check("decel reset", rd_q, 32'd1000);
    rd(8'h18);
    check("unmapped read", {rd_q[29:0], rresp_q}, 32'h2);
    wr(8'h18, 32'h1);
    check("unmapped write", bresp_q, 2'h2);
    $display("test registers done");
    for (c = 0; c < 4; c++) begin
      // limit settings rotate against power so settings 1 to 3 are seen with power on, setting 0 only with power forced off
      wr(`MEO_ADDR_CTRL, c | ((3 - c) << 2) | (((c + 1) % 4) << 4));
      restart;
      for (k = 0; k < 4; k++) begin
        v = $urandom;
        set_cmd({v[2:0], 3'b000});
        settle;
        pw = pwr_exp(2'(c), v[2]);
        check("power", drive_out.power_on, pw);
        check("fwd", drive_out.fwd_allow, pw && allow_exp(2'(3 - c), v[1]));
        check("rev", drive_out.rev_allow, pw && allow_exp(2'(c + 1), v[0]));
      end
    end
    wr(`MEO_ADDR_CTRL, 32'h2);
    settle;
    check("staged ctrl", drive_out.power_on, 0);
    $display("test polarity table done");
    for (m = 0; m < 3; m++) begin
      sof = $urandom % 3;
      slow = $urandom;
      wr(`MEO_ADDR_CTRL, (sof << 8) | (m << 6));
      restart;
      set_cmd(6'b111000);
      settle;
      check("power up", drive_out.power_on, 1);
      ot_trip(m, $urandom);
      if (m == 0) begin
        set_cmd(6'b011000);
        settle;
        set_cmd(6'b111000);
        settle;
        check("toggle on", drive_out.power_on, 1);
        ot_trip(0, 1'b1);
        wr(`MEO_ADDR_CMD, 32'h1);
        settle;
        check("serial on", drive_out.power_on, 1);
      end
    end
    // forced-on request never rises, so toggling the contact cannot clear the latch
    wr(`MEO_ADDR_CTRL, 32'h2 | (sof << 8));
    restart;
    set_cmd(6'b111000);
    settle;
    check("forced on", drive_out.power_on, 1);
    ot_trip(0, 1'b0);
    set_cmd(6'b011000);
    settle;
    set_cmd(6'b111000);
    settle;
    check("forced latch", drive_out.power_on, 0);
    restart;
    settle;
    check("supply cycle", drive_out.power_on, 1);
    $display("test stop methods done");
    d = 1 + $urandom % 99999999;
    wr(`MEO_ADDR_DECEL, d);
    rd(`MEO_ADDR_DECEL);
    check("decel", rd_q, d);
    @(negedge sys_clk);
    check("decel out", drive_out.decel_rate, d);
    for (k = 0; k < 3; k++) begin
      v = (k == 0) ? 32'd99999999 : (k == 1) ? 32'd0 : 32'd100000000;
      d = (k == 0) ? v : d;
      wr(`MEO_ADDR_DECEL, v);
      rd(`MEO_ADDR_DECEL);
      check("decel range", rd_q, d);
    end
    $display("test decel rate done");
    stop_test;
  end
  initial begin
    #600000;
    fail_count++;
    stop_test;
  end
endmodule
